// ### design/esdc_defs.svh
`ifndef ESDC_DEFS_SVH
`define ESDC_DEFS_SVH
// =====================================================
// address windows (32-bit form)
`define ESDC_GFX_LO 32'h1F000000
`define ESDC_GFX_HI 32'h1F3FFFFF
`define ESDC_SLOT0_LO 32'h1F400000
`define ESDC_SLOT0_HI 32'h1F5FFFFF
`define ESDC_SLOT1_LO 32'h1F600000
`define ESDC_SLOT1_HI 32'h1F9FFFFF
`define ESDC_WIDE_PREFIX 32'h90000000
// =====================================================
// apb register offsets of the host controller
`define ESDC_REG_CFG0 12'h000
`define ESDC_REG_CFG1 12'h004
`define ESDC_REG_STATUS 12'h008
`define ESDC_REG_MASK 12'h00C
`define ESDC_REG_INFO 12'h010
`define ESDC_REG_CADDR 12'h018
`define ESDC_REG_CWDATA 12'h01C
`define ESDC_REG_CGO 12'h020
`define ESDC_REG_CDATA 12'h024
// =====================================================
// slot setting field positions
`define ESDC_BIT_WIDE 0
`define ESDC_BIT_RT 1
`define ESDC_BIT_MST 2
`define ESDC_BIT_PIPE 3
`define ESDC_CFG_RESET 4'h8
// =====================================================
// card register offsets (within window)
`define ESDC_CARD_CMD 32'h00000000
`define ESDC_CARD_STAT 32'h00000004
`define ESDC_CARD_SCRATCH 32'h00000008
`endif

// ### design/esdc_pkg.sv
package esdc_pkg;
   // one slot's arbitration settings
   typedef struct packed {
      logic pipelined_protocol_setting;
      logic bus_master_setting;
      logic realtime_class_setting;
      logic wide_transfer_setting;
   } esdc_cfg_t;
   typedef enum logic [1:0] {ESDC_IDLE, ESDC_ADDR, ESDC_DATA} esdc_cyc_t;
endpackage : esdc_pkg

// ### design/esdc_if.sv
`timescale 1ns/100ps
interface esdc_if;
   import esdc_pkg::*;
   logic slot_id;
   logic wide_addr;
   logic as_valid;
   logic rd_wr;
   logic [63:0] ad_host;
   logic [63:0] ad_card;
   logic ad_card_oe;
   logic card_rdy;
   logic [2:0] irq_level;
   esdc_cfg_t cfg;
   modport host (output slot_id, wide_addr, as_valid, rd_wr, ad_host, cfg,
      input ad_card, ad_card_oe, card_rdy, irq_level);
   modport card (input slot_id, wide_addr, as_valid, rd_wr, ad_host, cfg,
      output ad_card, ad_card_oe, card_rdy, irq_level);
endinterface : esdc_if

// ### design/esdc_card.sv
// Functional notes
// - find own slot, answer only its window
// - graphics window 1F000000..1F3FFFFF, graphics only
// - slot zero window 1F400000..1F5FFFFF
// - slot one window 1F600000..1F9FFFFF
// - wide hosts prefix upper bits 90000000
// - non-graphics card interrupts on level one
// - never drive levels zero or two
// - synchronous multiplexed 64-bit bus, 32/64 cards
// - wide setting selects 64-bit transfers
// - realtime setting else long-burst requester
// - master setting allows mastering, else slave
// - pipelined setting set on dual-slot hosts
// - memory path non-pipelined, slots pipelined
// - two logical slots, numbered zero, one
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "esdc_defs.svh"
module esdc_card
   import esdc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus side
   esdc_if.card bus,
   // user side
   input wire logic event_in,
   output logic irq_pending,
   output logic [1:0] cfg_seen,
   output logic slot_seen
);
   // =====================================================
   // bus walk of one access, as the card sees it
   //   edge n   : address phase taken when as_valid and own window
   //   edge n+1 : data phase sampled, write data lands here
   //   edge n+2 : ready, read data and output enable stand
   // ready and output enable stand for exactly one cycle
   // the next address may follow at edge n+2 at the earliest
   // an address seen while in the address state is ignored
   // refused: other slot window, graphics window, bad wide prefix
   // refused: anything before the slot strap has been latched
   // narrow transfers return zeros in the upper data word
   // wide hosts put the fixed prefix in the upper address word
   // card registers within the window:
   //   offset 0 : write, bit 0 set clears the interrupt
   //   offset 4 : read, pipelined, realtime, slot, interrupt
   //   offset 8 : read and write scratch word
   // unknown offsets read as zero and ignore writes
   // an event and a clear in one cycle: the event wins
   // the interrupt is raised on the middle level only
   // master and realtime settings are passed to the user side
   // =====================================================
   // pin synchronisers for slot strap
   logic slot_s1;
   logic slot_s2;
   logic slot;
   logic slot_valid;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_s1 <= 1'b0;
         slot_s2 <= 1'b0;
      end else begin
         slot_s1 <= bus.slot_id;
         slot_s2 <= slot_s1;
      end
   end
   // slot latched once the strap has crossed both flops
   // hazard: the second flop still holds its reset value for two
   // edges after release, so the latch waits for the counter
   logic [1:0] slot_wait;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= 1'b0;
         slot_valid <= 1'b0;
         slot_wait <= 2'h0;
      end else if (!slot_valid) begin
         if (slot_wait == 2'h2) begin
            slot <= slot_s2;
            slot_valid <= 1'b1;
         end else begin
            slot_wait <= slot_wait + 2'h1;
         end
      end
   end
   // no access is claimed until the slot is known
   // =====================================================
   // address decode
   function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo,
      input logic [31:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction : in_win
   wire [31:0] addr_lo = bus.ad_host[31:0];
   wire prefix_ok = !bus.wide_addr || (bus.ad_host[63:32] == `ESDC_WIDE_PREFIX);
   wire hit0 = in_win(addr_lo, `ESDC_SLOT0_LO, `ESDC_SLOT0_HI);
   wire hit1 = in_win(addr_lo, `ESDC_SLOT1_LO, `ESDC_SLOT1_HI);
   // graphics window is never claimed by this card
   wire hit_gfx = in_win(addr_lo, `ESDC_GFX_LO, `ESDC_GFX_HI);
   wire hit = slot_valid && prefix_ok && !hit_gfx && (slot ? hit1 : hit0);
   // offset within own window, only meaningful on a hit
   wire [31:0] base = slot ? `ESDC_SLOT1_LO : `ESDC_SLOT0_LO;
   wire [31:0] offs = addr_lo - base;
   // =====================================================
   // cycle tracking: address phase then data phase (pipelined)
   esdc_cyc_t cyc;
   logic sel;
   logic wr;
   logic [31:0] reg_off;
   logic irq;
   logic [63:0] rdata;
   logic rdy;
   logic oe;
   logic [31:0] scratch;
   wire wide = bus.cfg.wide_transfer_setting;
   wire [63:0] stat_word = {32'h00000000, 28'h0000000, bus.cfg.pipelined_protocol_setting,
      bus.cfg.realtime_class_setting, slot, irq};
   // write data is on the bus while the card sits in the address state
   wire data_phase = sel && wr && (cyc == ESDC_ADDR);
   wire clr_hit = data_phase && (reg_off == `ESDC_CARD_CMD) && bus.ad_host[0];
   wire scr_hit = data_phase && (reg_off == `ESDC_CARD_SCRATCH);
   // read data select
   wire [63:0] scr_word = {32'h00000000, scratch};
   wire [63:0] rd_val = (reg_off == `ESDC_CARD_STAT) ? stat_word :
      (reg_off == `ESDC_CARD_SCRATCH) ? scr_word : 64'h0000000000000000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc <= ESDC_IDLE;
         sel <= 1'b0;
         wr <= 1'b0;
         reg_off <= 32'h00000000;
      end else begin
         case (cyc)
            ESDC_IDLE, ESDC_DATA: begin
               if (bus.as_valid && hit) begin
                  cyc <= ESDC_ADDR;
                  sel <= 1'b1;
                  wr <= bus.rd_wr;
                  reg_off <= offs;
               end else begin
                  cyc <= ESDC_IDLE;
                  sel <= 1'b0;
               end
            end
            ESDC_ADDR: begin
               cyc <= ESDC_DATA;
            end
            default: cyc <= ESDC_IDLE;
         endcase
      end
   end
   // data drive: one cycle in data phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= 64'h0000000000000000;
         rdy <= 1'b0;
         oe <= 1'b0;
      end else begin
         rdy <= (cyc == ESDC_ADDR) && sel;
         oe <= (cyc == ESDC_ADDR) && sel && !wr;
         rdata <= wide ? rd_val : {32'h00000000, rd_val[31:0]};
      end
   end
   // =====================================================
   // scratch word, written in the data phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scratch <= 32'h00000000;
      end else if (scr_hit) begin
         scratch <= bus.ad_host[31:0];
      end
   end
   // =====================================================
   // interrupt: sticky, cleared by card register write
   // set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (event_in) begin
         irq <= 1'b1;
      end else if (clr_hit) begin
         irq <= 1'b0;
      end
   end
   // =====================================================
   // bus outputs, each straight from a flop
   assign bus.ad_card = rdata;
   assign bus.ad_card_oe = oe;
   assign bus.card_rdy = rdy;
   // only the middle level is ever raised
   assign bus.irq_level = {1'b0, irq, 1'b0};
   // =====================================================
   // user side status
   assign irq_pending = irq;
   assign cfg_seen = {bus.cfg.bus_master_setting, bus.cfg.realtime_class_setting};
   assign slot_seen = slot;
endmodule : esdc_card

// ### design/esdc_host.sv
`timescale 1ns/100ps
`include "esdc_defs.svh"
module esdc_host
   import esdc_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // slot strap and bus
   input wire logic slot_strap,
   esdc_if.host bus
);
   // =====================================================
   // apb registers
   esdc_cfg_t cfg0;
   esdc_cfg_t cfg1;
   logic [31:0] info;
   logic status;
   logic mask;
   logic [1:0] lvl_s1;
   logic [1:0] lvl_s2;
   logic [31:0] caddr;
   logic [31:0] cwdata;
   logic [31:0] cdata;
   logic go_wr;
   logic go_wide;
   logic go_badpfx;
   esdc_cyc_t phase;
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire hit_cfg0 = paddr == `ESDC_REG_CFG0;
   wire hit_cfg1 = paddr == `ESDC_REG_CFG1;
   wire hit_stat = paddr == `ESDC_REG_STATUS;
   wire hit_mask = paddr == `ESDC_REG_MASK;
   wire hit_info = paddr == `ESDC_REG_INFO;
   wire hit_caddr = paddr == `ESDC_REG_CADDR;
   wire hit_cwdat = paddr == `ESDC_REG_CWDATA;
   wire hit_go = paddr == `ESDC_REG_CGO;
   wire hit_cdata = paddr == `ESDC_REG_CDATA;
   wire mapped = hit_cfg0 || hit_cfg1 || hit_stat || hit_mask || hit_info || hit_caddr
      || hit_cwdat || hit_go || hit_cdata;
   wire [31:0] rsel = hit_cfg0 ? {28'h0000000, cfg0} : hit_cfg1 ? {28'h0000000, cfg1} :
      hit_stat ? {31'h00000000, status} : hit_mask ? {31'h00000000, mask} :
      hit_info ? info : hit_caddr ? caddr : hit_cwdat ? cwdata :
      hit_cdata ? cdata : 32'h00000000;
   wire card_irq = lvl_s2[1]; // level one only
   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg0 <= `ESDC_CFG_RESET;
         cfg1 <= `ESDC_CFG_RESET;
         mask <= 1'b0;
         status <= 1'b0;
      end else begin
         if (wr && hit_cfg0) cfg0 <= pwdata[3:0];
         if (wr && hit_cfg1) cfg1 <= pwdata[3:0];
         if (wr && hit_mask) mask <= pwdata[0];
         if (card_irq) status <= 1'b1;
         else if (wr && hit_stat && pwdata[0]) status <= 1'b0;
      end
   end
   // answer, sync of level pins, info
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         lvl_s1 <= 2'h0;
         lvl_s2 <= 2'h0;
         info <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= rsel;
         irq <= status && mask;
         lvl_s1 <= bus.irq_level[1:0];
         lvl_s2 <= lvl_s1;
         info <= {29'h00000000, lvl_s2[1], bus.card_rdy, bus.ad_card_oe};
      end
   end
   // card access launcher: address phase, then one data phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         caddr <= 32'h00000000;
         cwdata <= 32'h00000000;
         cdata <= 32'h00000000;
         go_wr <= 1'b0;
         go_wide <= 1'b0;
         go_badpfx <= 1'b0;
         phase <= ESDC_IDLE;
      end else begin
         if (wr && hit_caddr) caddr <= pwdata;
         if (wr && hit_cwdat) cwdata <= pwdata;
         if (bus.card_rdy && bus.ad_card_oe) cdata <= bus.ad_card[31:0];
         case (phase)
            ESDC_IDLE: begin
               if (wr && hit_go) begin
                  phase <= ESDC_ADDR;
                  go_wr <= pwdata[0];
                  go_wide <= pwdata[1];
                  go_badpfx <= pwdata[2];
               end
            end
            ESDC_ADDR: phase <= ESDC_DATA;
            default: phase <= ESDC_IDLE;
         endcase
      end
   end
   // bad prefix is a test aid: wide address with zero upper word
   wire [31:0] pfx = (go_wide && !go_badpfx) ? `ESDC_WIDE_PREFIX : 32'h00000000;
   assign bus.slot_id = slot_strap;
   assign bus.wide_addr = go_wide;
   assign bus.as_valid = (phase == ESDC_ADDR);
   assign bus.rd_wr = go_wr;
   assign bus.ad_host = (phase == ESDC_ADDR) ? {pfx, caddr} :
      (phase == ESDC_DATA) ? {32'h00000000, cwdata} : 64'h0000000000000000;
   assign bus.cfg = slot_strap ? cfg1 : cfg0;
endmodule : esdc_host

// ### dv/esdc_properties.sv
`timescale 1ns/100ps
`include "esdc_defs.svh"
module esdc_properties
   import esdc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus signals
   input wire logic slot_id,
   input wire logic wide_addr,
   input wire logic as_valid,
   input wire logic [63:0] ad_host,
   input wire logic [63:0] ad_card,
   input wire logic ad_card_oe,
   input wire logic card_rdy,
   input wire logic [2:0] irq_level,
   input wire esdc_cfg_t cfg
);
   // =====================================
   // window decode of the address phase
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire [31:0] a = ad_host[31:0];
   wire in_gfx = a >= `ESDC_GFX_LO && a <= `ESDC_GFX_HI;
   wire in_s0 = a >= `ESDC_SLOT0_LO && a <= `ESDC_SLOT0_HI;
   wire in_s1 = a >= `ESDC_SLOT1_LO && a <= `ESDC_SLOT1_HI;
   wire pre_ok = !wide_addr || ad_host[63:32] == `ESDC_WIDE_PREFIX;
   wire own = pre_ok && (slot_id ? in_s1 : in_s0);
   sequence s_foreign;
      as_valid && !own;
   endsequence
   // =====================================
   // properties
   a_slot0_hit: assert property (as_valid && pre_ok && !slot_id && in_s0 |-> ##2 card_rdy)
      else $error("slot zero access not answered");
   a_slot1_hit: assert property (as_valid && pre_ok && slot_id && in_s1 |-> ##2 card_rdy)
      else $error("slot one access not answered");
   a_gfx_refused: assert property (as_valid && in_gfx |-> ##2 !card_rdy)
      else $error("graphics window answered");
   a_foreign_refused: assert property (s_foreign |-> ##2 !card_rdy)
      else $error("foreign address answered");
   a_prefix_refused: assert property (as_valid && !pre_ok |-> ##2 !card_rdy)
      else $error("bad wide prefix answered");
   a_rdy_single: assert property (card_rdy |=> !card_rdy)
      else $error("ready held too long");
   a_rdy_has_cause: assert property ($rose(card_rdy) |-> $past(as_valid, 2))
      else $error("ready without address phase");
   a_irq_level_one: assert property (irq_level[0] == 1'b0 && irq_level[2] == 1'b0)
      else $error("reserved interrupt level driven");
   a_narrow_upper: assert property (ad_card_oe && !cfg.wide_transfer_setting
      |-> ad_card[63:32] == 32'h0)
      else $error("upper word driven in narrow mode");
endmodule : esdc_properties

// ### dv/tb.sv
`timescale 1ns/100ps
`include "esdc_defs.svh"
module tb;
   // =====================================
   // stimulus and observed signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic slot_strap = 1'b0;
   logic event_in = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, irq, irq_pending, slot_seen;
   wire [1:0] cfg_seen;
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   always #12.5 pclk = ~pclk;
   esdc_if bus_if();
   esdc_host u_esdc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .slot_strap(slot_strap), .bus(bus_if));
   esdc_card u_esdc_card (.pclk(pclk), .presetn(presetn), .bus(bus_if), .event_in(event_in),
      .irq_pending(irq_pending), .cfg_seen(cfg_seen), .slot_seen(slot_seen));
   esdc_properties u_esdc_properties (.pclk(pclk), .presetn(presetn),
      .slot_id(bus_if.slot_id), .wide_addr(bus_if.wide_addr), .as_valid(bus_if.as_valid),
      .ad_host(bus_if.ad_host), .ad_card(bus_if.ad_card), .ad_card_oe(bus_if.ad_card_oe),
      .card_rdy(bus_if.card_rdy), .irq_level(bus_if.irq_level), .cfg(bus_if.cfg));
   // =====================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // ctl bit 0 write, bit 1 wide address, bit 2 bad prefix
   task automatic card_acc(input logic [2:0] ctl, input logic [31:0] a,
      input logic [31:0] d);
      apb(1'b1, `ESDC_REG_CADDR, a);
      apb(1'b1, `ESDC_REG_CWDATA, d);
      apb(1'b1, `ESDC_REG_CGO, {29'h0, ctl});
      repeat (4) @(posedge pclk);
   endtask : card_acc
   task automatic complete_run();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   // timeout watchdog
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         complete_run();
      end
   end
   // =====================================
   // main sequence: both slots, settings, interrupt, unmapped access
   initial begin
      for (int s = 0; s < 2; s++) begin
         slot_strap <= s[0];
         presetn <= 1'b0;
         repeat (16) @(posedge pclk);
         presetn <= 1'b1;
         repeat (6) @(posedge pclk);
         chk(slot_seen, s[0]);
         apb(1'b0, s ? `ESDC_REG_CFG1 : `ESDC_REG_CFG0, 32'h0);
         chk(rd, `ESDC_CFG_RESET);
         for (int b = 0; b < 4; b++) begin
            apb(1'b1, s ? `ESDC_REG_CFG1 : `ESDC_REG_CFG0, 32'h8 | (32'h1 << b));
            @(posedge pclk);
            chk(bus_if.cfg, 32'h8 | (32'h1 << b));
            chk(cfg_seen, {30'h0, b == 2, b == 1});
         end
      end
      event_in <= 1'b1;
      repeat (2) @(posedge pclk);
      event_in <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(irq_pending, 1'b1);
      chk(bus_if.irq_level, 3'h2);
      apb(1'b1, `ESDC_REG_MASK, 32'h0);
      @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, `ESDC_REG_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b0, `ESDC_REG_STATUS, 32'h0);
      chk(rd[0], 1'b1);
      apb(1'b1, `ESDC_REG_STATUS, 32'h1);
      repeat (10) @(posedge pclk);
      apb(1'b0, 12'h014, 32'h0);
      chk(err, 1'b1);
      card_acc(3'h0, 32'h1F600004, 32'h0);
      apb(1'b0, `ESDC_REG_CDATA, 32'h0);
      chk(rd, 32'hB);
      card_acc(3'h1, 32'h1F400000, 32'h1);
      chk(irq_pending, 1'b1);
      card_acc(3'h1, 32'h1F000000, 32'h1);
      chk(irq_pending, 1'b1);
      card_acc(3'h7, 32'h1F600000, 32'h1);
      chk(irq_pending, 1'b1);
      card_acc(3'h1, 32'h1F600008, 32'hA5C30F1E);
      card_acc(3'h2, 32'h1F600008, 32'h0);
      apb(1'b0, `ESDC_REG_CDATA, 32'h0);
      chk(rd, 32'hA5C30F1E);
      card_acc(3'h3, 32'h1F600000, 32'h1);
      chk(irq_pending, 1'b0);
      apb(1'b1, `ESDC_REG_STATUS, 32'h1);
      apb(1'b0, `ESDC_REG_STATUS, 32'h0);
      chk(rd[0], 1'b0);
      chk(irq, 1'b0);
      complete_run();
   end
endmodule : tb
